/* File: hdl/twm_master.sv */
/*
 * two-wire master transmitter with axi4-lite registers: control, status
 * code and shift byte. holds the bus with scl low while the step flag from a start or an ack is set.
 * assumes open-drain pads outside (oe high pulls the wire low) and pull-ups.
 */
`include "twm_defines.svh"
module twm_master
  import twm_pkg::*;
#(
  parameter int QUARTER_CYC = `TWM_QUARTER_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  // synchronised pin levels
  logic scl_s;
  logic sda_s;
  twm_sync u_scl (.aclk(aclk), .aresetn(aresetn), .pin_in(scl_in), .pin_sync(scl_s));
  twm_sync u_sda (.aclk(aclk), .aresetn(aresetn), .pin_in(sda_in), .pin_sync(sda_s));

  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] data_reg, data_next;
  logic aw_reg, aw_next, w_reg, w_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [7:0] wbyte_reg, wbyte_next;
  logic wlane_reg, wlane_next;
  logic bvalid_reg, bvalid_next, bad_w_reg, bad_w_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  twm_state_t state_reg, state_next;
  logic [1:0] phase_reg, phase_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic busy_reg, busy_next, is_addr_reg, is_addr_next;
  logic scl_low_reg, scl_low_next, sda_low_reg, sda_low_next;
  logic bus_free;
  logic tick;
  logic do_write;
  logic step_set;
  logic [7:0] step_code;
  logic [7:0] ack_code_reg, ack_code_next; // ack level latched mid high phase, posted when scl falls

  assign tick = (cnt_reg == 16'h0000);
  assign bus_free = scl_s && sda_s && !busy_reg;
  assign do_write = aw_reg && w_reg && !bvalid_reg;

  // bus slave handshakes; address and data caught in either order
  assign s_axi_awready = !aw_reg && !bvalid_reg;
  assign s_axi_wready = !w_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bad_w_reg ? 2'h2 : 2'h0;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq = ctrl_reg[`TWM_B_STEP] && ctrl_reg[`TWM_B_IE];
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low_reg;
  assign sda_oe = sda_low_reg;

  // bus slave next state
  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    awaddr_next = awaddr_reg;
    wbyte_next = wbyte_reg;
    wlane_next = wlane_reg;
    bvalid_next = bvalid_reg;
    bad_w_next = bad_w_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next = 1'b1;
      wbyte_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bvalid_next = 1'b1;
      bad_w_next = !(awaddr_reg == `TWM_OFS_CONTROL || awaddr_reg == `TWM_OFS_DATA
                     || awaddr_reg == `TWM_OFS_STATUS);
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      case (s_axi_araddr)
        `TWM_OFS_CONTROL: rdata_next = {24'h000000, ctrl_reg};
        `TWM_OFS_STATUS: rdata_next = {24'h000000, status_reg & `TWM_ST_MASK};
        `TWM_OFS_DATA: rdata_next = {24'h000000, data_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = 2'h2;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // bus engine: quarter-period ticks walk start, bits, ack, stop
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next = tick ? 16'(QUARTER_CYC - 1) : cnt_reg - 16'h0001;
    bit_next = bit_reg;
    busy_next = busy_reg;
    is_addr_next = is_addr_reg;
    scl_low_next = scl_low_reg;
    sda_low_next = sda_low_reg;
    step_set = 1'b0;
    step_code = status_reg;
    ack_code_next = ack_code_reg;
    if (!ctrl_reg[`TWM_B_EN]) begin
      state_next = TWM_IDLE;
      scl_low_next = 1'b0;
      sda_low_next = 1'b0;
      busy_next = 1'b0;
    end else if (tick) begin
      phase_next = phase_reg + 2'h1;
      case (state_reg)
        TWM_IDLE, TWM_HOLD: begin
          phase_next = 2'h0;
          // nothing moves while the step flag is set
          if (!ctrl_reg[`TWM_B_STEP]) begin
            if (ctrl_reg[`TWM_B_STOP] && busy_reg) begin
              state_next = TWM_STOP;
            end else if (ctrl_reg[`TWM_B_START]) begin
              state_next = busy_reg ? TWM_START : TWM_WAIT_FREE;
            end else if (busy_reg && state_reg == TWM_HOLD) begin
              state_next = TWM_BIT;
              bit_next = 4'h7;
            end
          end
        end
        TWM_WAIT_FREE: begin
          phase_next = 2'h0;
          if (bus_free) begin
            state_next = TWM_START;
          end
        end
        TWM_START: begin
          // phases: release sda, raise scl, pull sda, pull scl
          case (phase_reg)
            2'h0: sda_low_next = 1'b0;
            2'h1: scl_low_next = 1'b0;
            2'h2: sda_low_next = 1'b1;
            default: begin
              scl_low_next = 1'b1;
              step_set = 1'b1;
              step_code = busy_reg ? `TWM_ST_RSTART : `TWM_ST_START;
              busy_next = 1'b1;
              is_addr_next = 1'b1;
              state_next = TWM_HOLD;
            end
          endcase
        end
        TWM_BIT, TWM_ACK: begin
          case (phase_reg)
            2'h0: sda_low_next = (state_reg == TWM_BIT) && !data_reg[bit_reg[2:0]];
            2'h1: scl_low_next = 1'b0;
            2'h2: begin
              if (state_reg == TWM_BIT && !sda_low_reg && !sda_s) begin
                // someone else pulled sda low: let go of the bus
                scl_low_next = 1'b0;
                sda_low_next = 1'b0;
                busy_next = 1'b0;
                step_set = 1'b1;
                step_code = `TWM_ST_ARB_LOST;
                state_next = TWM_IDLE;
              end else if (state_reg == TWM_ACK) begin
                // low level is an acknowledge
                step_code = is_addr_reg ? (sda_s ? `TWM_ST_ADDR_NACK : `TWM_ST_ADDR_ACK)
                                        : (sda_s ? `TWM_ST_DATA_NACK : `TWM_ST_DATA_ACK);
                ack_code_next = step_code;
              end
            end
            default: begin
              scl_low_next = 1'b1;
              if (state_reg == TWM_ACK) begin
                step_set = 1'b1;
                step_code = ack_code_reg;
                is_addr_next = 1'b0;
                state_next = TWM_HOLD;
              end else if (bit_reg == 4'h0) begin
                state_next = TWM_ACK;
              end else begin
                bit_next = bit_reg - 4'h1;
              end
            end
          endcase
        end
        TWM_STOP: begin
          case (phase_reg)
            2'h0: sda_low_next = 1'b1;
            2'h1: scl_low_next = 1'b0;
            2'h2: sda_low_next = 1'b0;
            default: begin
              busy_next = 1'b0;
              state_next = TWM_IDLE;
            end
          endcase
        end
        default: state_next = TWM_IDLE;
      endcase
    end
  end

  // registers written by software and by the engine
  always_comb begin
    ctrl_next = ctrl_reg;
    status_next = status_reg;
    data_next = data_reg;
    if (do_write && wlane_reg && awaddr_reg == `TWM_OFS_CONTROL) begin
      // flag cleared by a one, collision bit kept
      ctrl_next = {ctrl_reg[7] && !wbyte_reg[7], wbyte_reg[6:4], ctrl_reg[3], wbyte_reg[2], 1'b0,
                   wbyte_reg[0]};
    end
    if (do_write && wlane_reg && awaddr_reg == `TWM_OFS_DATA) begin
      if (ctrl_reg[`TWM_B_STEP]) begin
        data_next = wbyte_reg;
        ctrl_next[`TWM_B_WCOL] = 1'b0;
      end else begin
        ctrl_next[`TWM_B_WCOL] = 1'b1;
      end
    end
    if (state_reg == TWM_STOP && tick && phase_reg == 2'h3) begin
      ctrl_next[`TWM_B_STOP] = 1'b0;
    end
    if (state_reg == TWM_START && tick && phase_reg == 2'h3) begin
      ctrl_next[`TWM_B_START] = 1'b0; // start request consumed once issued
    end
    // hardware set beats a same-cycle software clear
    if (step_set) begin
      ctrl_next[`TWM_B_STEP] = 1'b1;
      status_next = step_code;
    end
  end

  // state registers; mode choice itself is left to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `TWM_CONTROL_RST;
      status_reg <= `TWM_ST_IDLE;
      data_reg <= `TWM_DATA_RST;
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bad_w_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
      state_reg <= TWM_IDLE;
      phase_reg <= 2'h0;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h7;
      busy_reg <= 1'b0;
      is_addr_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      ack_code_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      data_reg <= data_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      awaddr_reg <= awaddr_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      bvalid_reg <= bvalid_next;
      bad_w_reg <= bad_w_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      busy_reg <= busy_next;
      is_addr_reg <= is_addr_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      ack_code_reg <= ack_code_next;
    end
  end

  // scl is held low while the flag is set in the hold state with the bus owned
  chk_hold_scl_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg[`TWM_B_STEP] && busy_reg && state_reg == TWM_HOLD) |-> scl_oe)
    else $error("scl released while step flag set");
  chk_start_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == TWM_START && tick && phase_reg == 2'h3 && !busy_reg && ctrl_reg[`TWM_B_EN])
    |=> (ctrl_reg[`TWM_B_STEP] && status_reg == `TWM_ST_START))
    else $error("start did not post 0x08");
  chk_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wlane_reg && awaddr_reg == `TWM_OFS_CONTROL && !wbyte_reg[7] && ctrl_reg[7])
    |=> ctrl_reg[7])
    else $error("zero write cleared step flag");
  chk_wcol_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wlane_reg && awaddr_reg == `TWM_OFS_DATA && !ctrl_reg[7])
    |=> (ctrl_reg[`TWM_B_WCOL] && $stable(data_reg)))
    else $error("collision not caught");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == (ctrl_reg[7] && ctrl_reg[0]))
    else $error("interrupt level wrong");
  chk_enable_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_reg[`TWM_B_EN] |=> ##1 (!scl_oe && !sda_oe))
    else $error("bus driven while disabled");
  chk_stop_self: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == TWM_STOP && tick && phase_reg == 2'h3 && ctrl_reg[`TWM_B_EN])
    |=> (!ctrl_reg[`TWM_B_STOP] && !busy_reg))
    else $error("stop request not cleared");
  chk_arb_release: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(status_reg) && status_reg == `TWM_ST_ARB_LOST) |-> (!scl_oe && !sda_oe))
    else $error("bus held after arbitration loss");
endmodule : twm_master

/* File: hdl/twm_defines.svh */
/*
 * constants of the two-wire master transmitter: register offsets, control bit
 * positions, status codes, reset values and bus timing counts.
 * assumes a 25 MHz aclk and inclusion by bare name.
 */
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH

`define TWM_CLK_HZ 25000000
// register byte offsets on the axi4-lite bus
`define TWM_OFS_CONTROL 8'h00
`define TWM_OFS_STATUS 8'h04
`define TWM_OFS_DATA 8'h08
// control register bit positions
`define TWM_B_STEP 7
`define TWM_B_ACKEN 6
`define TWM_B_START 5
`define TWM_B_STOP 4
`define TWM_B_WCOL 3
`define TWM_B_EN 2
`define TWM_B_IE 0
`define TWM_CONTROL_RST 8'h00
`define TWM_DATA_RST 8'hff
// status codes, low three bits are prescaler bits and read zero here
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_ADDR_ACK 8'h18
`define TWM_ST_ADDR_NACK 8'h20
`define TWM_ST_DATA_ACK 8'h28
`define TWM_ST_DATA_NACK 8'h30
`define TWM_ST_ARB_LOST 8'h38
`define TWM_ST_IDLE 8'hf8
`define TWM_ST_MASK 8'hf8
// scl quarter period: 100 kHz bus -> 2.5 us per quarter
`define TWM_QUARTER_NS 2500
`define TWM_QUARTER_CYC (`TWM_QUARTER_NS * 25 / 1000)

`endif

/* File: hdl/twm_pkg.sv */
/*
 * types shared by the two-wire master transmitter.
 * assumes nothing beyond a systemverilog compiler.
 */
package twm_pkg;
  typedef enum logic [3:0] {
    TWM_IDLE, TWM_WAIT_FREE, TWM_START, TWM_BIT, TWM_ACK, TWM_HOLD, TWM_STOP
  } twm_state_t;
endpackage : twm_pkg

/* File: hdl/twm_sync.sv */
/*
 * two flip-flop synchroniser for one pin level.
 * assumes the pin is asynchronous to aclk; only the second stage is read.
 */
module twm_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  output logic pin_sync
);
  logic meta_reg;
  logic meta_next;
  logic sync_next;

  // next values are the plain shift
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
  end

  // idle bus level is high, so reset to one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      pin_sync <= sync_next;
    end
  end
endmodule : twm_sync

/* File: bench/twm_slave_model.sv */
/*
 * behavioural i2c slave receiver for the two-wire master bench.
 * assumes the bench resolves the open-drain wires, with pull-ups.
 */
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  output logic [7:0] last_byte,
  output logic stop_seen,
  output int nbytes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shift = 8'h00;
  int bitcnt = 0;
  logic first = 1'b0;
  logic chosen = 1'b0;
  initial begin
    sda_pull = 1'b0;
    last_byte = 8'h00;
    stop_seen = 1'b0;
    nbytes = 0;
  end
  // start or repeated start restarts the bit count and expects an address byte
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitcnt = 0;
      first = 1'b1;
      stop_seen = 1'b0;
    end
  end
  // stop ends the frame
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stop_seen = 1'b1;
      bitcnt = 0;
    end
  end
  // bits taken on the rising clock, msb first
  always @(posedge scl) begin
    if (bitcnt < 8) begin
      shift = {shift[6:0], sda};
      bitcnt++;
    end
  end
  // ack only when our address came with the write bit; released after the ninth clock
  always @(negedge scl) begin
    if (bitcnt == 8) begin
      last_byte = shift;
      nbytes++;
      if (first) chosen = (shift[7:1] == ADDR) && !shift[0];
      first = 1'b0;
      sda_pull = chosen;
      bitcnt = 9;
    end else if (bitcnt == 9) begin
      sda_pull = 1'b0;
      bitcnt = 0;
    end
  end
endmodule : twm_slave_model

/* File: bench/twm_master_tb.sv */
/*
 * self-checking bench of the two-wire master transmitter.
 * assumes the axi4-lite map of the defines header and pull-ups on both wires.
 */
`include "twm_defines.svh"
module twm_master_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, scl_out, scl_oe, sda_out, sda_oe, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0] r;
  logic [1:0] last_bresp = 2'h0;
  logic other_pull = 1'b0;
  logic sda_pull, stop_seen;
  logic [7:0] last_byte;
  int nbytes;
  int errors = 0, num_checks = 0;
  wire logic scl_w, sda_w;
  // open-drain wires: anyone pulling wins, else pull-up
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || sda_pull || other_pull);

  twm_master #(.QUARTER_CYC(4)) twm_master_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  twm_slave_model twm_slave_model_inst (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull),
    .last_byte(last_byte), .stop_seen(stop_seen), .nbytes(nbytes));

  // 40 ns clock
  initial begin
    forever #20 aclk = !aclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  // poll the step flag, then compare the masked status code
  task automatic wait_step(input logic [7:0] exp);
    for (int i = 0; i < 3000; i++) begin
      rd(`TWM_OFS_CONTROL, d, r);
      if (d[`TWM_B_STEP] === 1'b1) break;
    end
    check({31'h0, d[`TWM_B_STEP]}, 32'h1);
    rd(`TWM_OFS_STATUS, d, r);
    check(d & `TWM_ST_MASK, {24'h0, exp});
  endtask : wait_step

  // load the byte first, then clear the flag with enable kept
  task automatic send(input logic [7:0] b, input logic [7:0] exp);
    wr(`TWM_OFS_DATA, b);
    wr(`TWM_OFS_CONTROL, 8'h84);
    wait_step(exp);
  endtask : send

  task automatic t_reset_values();
    rd(`TWM_OFS_CONTROL, d, r);
    check(d, 32'h0);
    rd(`TWM_OFS_STATUS, d, r);
    check(d, 32'hf8);
    rd(`TWM_OFS_DATA, d, r);
    check(d, 32'hff);
    check({30'h0, r}, 32'h0);
    rd(8'h0c, d, r);
    check({30'h0, r}, 32'h2);
    // unmapped write must answer with an error response
    wr(8'h0c, 8'h12);
    check({30'h0, last_bresp}, 32'h2);
  endtask : t_reset_values

  // data write with the flag low is dropped and flagged
  task automatic t_collision();
    wr(`TWM_OFS_DATA, 8'h55);
    check({30'h0, last_bresp}, 32'h0);
    rd(`TWM_OFS_CONTROL, d, r);
    check({31'h0, d[`TWM_B_WCOL]}, 32'h1);
    rd(`TWM_OFS_DATA, d, r);
    check(d, 32'hff);
  endtask : t_collision

  // start request without enable must leave the wires alone
  task automatic t_enable_off();
    wr(`TWM_OFS_CONTROL, 8'ha0);
    repeat (200) @(posedge aclk);
    check({30'h0, scl_oe, sda_oe}, 32'h0);
    check({30'h0, scl_out, sda_out}, 32'h0);
    wr(`TWM_OFS_CONTROL, 8'h00);
  endtask : t_enable_off

  task automatic t_transfer();
    wr(`TWM_OFS_CONTROL, 8'ha5);
    wait_step(`TWM_ST_START);
    check({31'h0, irq}, 32'h1);
    repeat (100) @(posedge aclk);
    check({31'h0, scl_oe}, 32'h1);
    check(nbytes, 32'h0);
    wr(`TWM_OFS_CONTROL, 8'h04);
    rd(`TWM_OFS_CONTROL, d, r);
    check({31'h0, d[`TWM_B_STEP]}, 32'h1);
    check({31'h0, irq}, 32'h0);
    send(8'ha0, `TWM_ST_ADDR_ACK);
    check({24'h0, last_byte}, 32'ha0);
    send(8'h3c, `TWM_ST_DATA_ACK);
    check({24'h0, last_byte}, 32'h3c);
    wr(`TWM_OFS_CONTROL, 8'ha4);
    wait_step(`TWM_ST_RSTART);
    send(8'hb2, `TWM_ST_ADDR_NACK);
    send(8'h81, `TWM_ST_DATA_NACK);
    check(nbytes, 32'h4);
    check({31'h0, stop_seen}, 32'h0);
    wr(`TWM_OFS_CONTROL, 8'h94);
    for (int i = 0; i < 500; i++) begin
      rd(`TWM_OFS_CONTROL, d, r);
      if (d[`TWM_B_STOP] === 1'b0) break;
    end
    check({31'h0, d[`TWM_B_STOP]}, 32'h0);
    repeat (50) @(posedge aclk);
    check({31'h0, stop_seen}, 32'h1);
    check({30'h0, scl_oe, sda_oe}, 32'h0);
  endtask : t_transfer

  // another master holds sda low while we send a one bit
  task automatic t_arbitration();
    wr(`TWM_OFS_CONTROL, 8'ha4);
    wait_step(`TWM_ST_START);
    other_pull <= 1'b1;
    send(8'ha0, `TWM_ST_ARB_LOST);
    check({31'h0, sda_oe}, 32'h0);
    other_pull <= 1'b0;
  endtask : t_arbitration

  // reset for 16 cycles, then the scenarios in turn
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_collision();
    t_enable_off();
    t_transfer();
    t_arbitration();
    print_verdict();
  end

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge aclk);
    errors++;
    print_verdict();
  end
endmodule : twm_master_tb
